// [logic/smsw_pkg.sv]
package smsw_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LVL_W = 16;
   localparam int REF_W = 32;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_SEL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TRQ = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SPD = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ACC = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_DEV = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;

   // ----------------------------------------------------------------
   // fields
   // ----------------------------------------------------------------
   localparam int SEL_W = 4;
   localparam int STAT_PMODE_BIT = 0;
   localparam int STAT_ARMED_BIT = 1;
   localparam int STAT_POSCTL_BIT = 2;

   // ----------------------------------------------------------------
   // switching condition selection
   // ----------------------------------------------------------------
   typedef enum logic [SEL_W-1:0] {
      SEL_TORQUE = 4'h0,
      SEL_SPEED = 4'h1,
      SEL_ACCEL = 4'h2,
      SEL_DEVIATION = 4'h3,
      SEL_OFF = 4'h4
   } smsw_sel_t;

   // ----------------------------------------------------------------
   // reset values and ranges
   // ----------------------------------------------------------------
   localparam logic [SEL_W-1:0] SEL_RST = 4'h4;
   localparam logic [LVL_W-1:0] TRQ_LVL_RST = 16'h00C8;
   localparam logic [LVL_W-1:0] SPD_LVL_RST = 16'h0000;
   localparam logic [LVL_W-1:0] ACC_LVL_RST = 16'h0000;
   localparam logic [LVL_W-1:0] DEV_LVL_RST = 16'h0000;
   localparam logic [LVL_W-1:0] TRQ_LVL_MAX = 16'h0320;
   localparam logic [LVL_W-1:0] SPD_LVL_MAX = 16'h2710;
   localparam logic [LVL_W-1:0] ACC_LVL_MAX = 16'h7530;
   localparam logic [LVL_W-1:0] DEV_LVL_MAX = 16'h2710;

   // ----------------------------------------------------------------
   // bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // magnitude of a signed reference
   function automatic logic [REF_W-1:0] smsw_mag(input logic signed [REF_W-1:0] v);
      smsw_mag = v[REF_W-1] ? REF_W'(-v) : REF_W'(v);
   endfunction

endpackage

// [logic/smsw_cmp_if.sv]
`timescale 1ns/100ps
interface smsw_cmp_if import smsw_pkg::*; ();
   logic [SEL_W-1:0] sel;
   logic [LVL_W-1:0] trq_lvl;
   logic [LVL_W-1:0] spd_lvl;
   logic [LVL_W-1:0] acc_lvl;
   logic [LVL_W-1:0] dev_lvl;
   logic signed [REF_W-1:0] torque_ref;
   logic signed [REF_W-1:0] speed_ref;
   logic signed [REF_W-1:0] accel_ref;
   logic signed [REF_W-1:0] pos_dev;
   logic pos_ctrl_mode;
   logic cond;

   modport ctl (
      output sel, trq_lvl, spd_lvl, acc_lvl, dev_lvl,
      output torque_ref, speed_ref, accel_ref, pos_dev, pos_ctrl_mode,
      input cond
   );
   modport cmp (
      input sel, trq_lvl, spd_lvl, acc_lvl, dev_lvl,
      input torque_ref, speed_ref, accel_ref, pos_dev, pos_ctrl_mode,
      output cond
   );
endinterface

// [logic/smsw_cmp.sv]
`timescale 1ns/100ps
module smsw_cmp import smsw_pkg::*; (
   // settings and references
   smsw_cmp_if.cmp c
);

   // ----------------------------------------------------------------
   // condition select and compare
   // ----------------------------------------------------------------
   always_comb begin
      case (c.sel)
         SEL_TORQUE: begin
            c.cond = smsw_mag(c.torque_ref) >= REF_W'(c.trq_lvl);
         end
         SEL_SPEED: begin
            c.cond = smsw_mag(c.speed_ref) >= REF_W'(c.spd_lvl);
         end
         SEL_ACCEL: begin
            c.cond = smsw_mag(c.accel_ref) >= REF_W'(c.acc_lvl);
         end
         SEL_DEVIATION: begin
            // outside position control this choice never switches
            c.cond = c.pos_ctrl_mode && (smsw_mag(c.pos_dev) >= REF_W'(c.dev_lvl));
         end
         default: begin
            c.cond = 1'b0;
         end
      endcase
   end

endmodule

// [logic/smsw_top.sv]
`timescale 1ns/100ps
module smsw_top import smsw_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // references from the control loops
   input wire logic signed [REF_W-1:0] torque_ref,
   input wire logic signed [REF_W-1:0] speed_ref,
   input wire logic signed [REF_W-1:0] accel_ref,
   input wire logic signed [REF_W-1:0] pos_dev,
   input wire logic pos_ctrl_mode,
   // speed loop mode
   output logic p_mode
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [LVL_W-1:0] wr_lvl(input logic [LVL_W-1:0] old,
                                              input logic [DATA_W-1:0] d,
                                              input logic [3:0] s,
                                              input logic [LVL_W-1:0] lim);
      logic [LVL_W-1:0] v;
      v = old;
      if (s[0]) begin
         v[7:0] = d[7:0];
      end
      if (s[1]) begin
         v[15:8] = d[15:8];
      end
      // out-of-range writes saturate so the loop never sees a bogus level
      wr_lvl = (v > lim) ? lim : v;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFS_SEL) || (a == OFS_TRQ) || (a == OFS_SPD) || (a == OFS_ACC)
               || (a == OFS_DEV) || (a == OFS_STAT);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [SEL_W-1:0] sel_r;
   logic [LVL_W-1:0] trq_lvl_r;
   logic [LVL_W-1:0] spd_lvl_r;
   logic [LVL_W-1:0] acc_lvl_r;
   logic [LVL_W-1:0] dev_lvl_r;
   logic p_mode_r;
   logic aw_held_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic w_held_r;
   logic [DATA_W-1:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic do_wr;
   logic [DATA_W-1:0] rd_nxt;

   smsw_cmp_if cif ();

   // ----------------------------------------------------------------
   // comparator
   // ----------------------------------------------------------------
   assign cif.sel = sel_r;
   assign cif.trq_lvl = trq_lvl_r;
   assign cif.spd_lvl = spd_lvl_r;
   assign cif.acc_lvl = acc_lvl_r;
   assign cif.dev_lvl = dev_lvl_r;
   assign cif.torque_ref = torque_ref;
   assign cif.speed_ref = speed_ref;
   assign cif.accel_ref = accel_ref;
   assign cif.pos_dev = pos_dev;
   assign cif.pos_ctrl_mode = pos_ctrl_mode;

   smsw_cmp u_cmp (
      .c (cif.cmp)
   );

   // ----------------------------------------------------------------
   // mode output
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p_mode_r <= 1'b0;
      end else begin
         p_mode_r <= cif.cond;
      end
   end

   assign p_mode = p_mode_r;

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   assign awready = !aw_held_r && !bvalid_r;
   assign wready = !w_held_r && !bvalid_r;
   assign do_wr = aw_held_r && w_held_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (awvalid && awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= awaddr;
      end else if (do_wr) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end else if (wvalid && wready) begin
         w_held_r <= 1'b1;
         w_data_r <= wdata;
         w_strb_r <= wstrb;
      end else if (do_wr) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r <= (mapped(aw_addr_r) && aw_addr_r != OFS_STAT) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // settings registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_r <= SEL_RST;
      end else if (do_wr && aw_addr_r == OFS_SEL && w_strb_r[0]) begin
         sel_r <= w_data_r[SEL_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trq_lvl_r <= TRQ_LVL_RST;
      end else if (do_wr && aw_addr_r == OFS_TRQ) begin
         trq_lvl_r <= wr_lvl(trq_lvl_r, w_data_r, w_strb_r, TRQ_LVL_MAX);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spd_lvl_r <= SPD_LVL_RST;
         acc_lvl_r <= ACC_LVL_RST;
         dev_lvl_r <= DEV_LVL_RST;
      end else if (do_wr) begin
         if (aw_addr_r == OFS_SPD) begin
            spd_lvl_r <= wr_lvl(spd_lvl_r, w_data_r, w_strb_r, SPD_LVL_MAX);
         end
         if (aw_addr_r == OFS_ACC) begin
            acc_lvl_r <= wr_lvl(acc_lvl_r, w_data_r, w_strb_r, ACC_LVL_MAX);
         end
         if (aw_addr_r == OFS_DEV) begin
            dev_lvl_r <= wr_lvl(dev_lvl_r, w_data_r, w_strb_r, DEV_LVL_MAX);
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   assign arready = !rvalid_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   always_comb begin
      rd_nxt = 32'h00000000;
      case (araddr)
         OFS_SEL: rd_nxt[SEL_W-1:0] = sel_r;
         OFS_TRQ: rd_nxt[LVL_W-1:0] = trq_lvl_r;
         OFS_SPD: rd_nxt[LVL_W-1:0] = spd_lvl_r;
         OFS_ACC: rd_nxt[LVL_W-1:0] = acc_lvl_r;
         OFS_DEV: rd_nxt[LVL_W-1:0] = dev_lvl_r;
         OFS_STAT: begin
            rd_nxt[STAT_PMODE_BIT] = p_mode_r;
            rd_nxt[STAT_ARMED_BIT] = sel_r < SEL_OFF;
            rd_nxt[STAT_POSCTL_BIT] = pos_ctrl_mode;
         end
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_nxt;
         rresp_r <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_P_FOLLOWS_COND: assert property (p_mode |-> $past(cif.cond))
      else $error("p mode without trigger");
   AST_PI_WHEN_CLEAR: assert property (!cif.cond |=> !p_mode)
      else $error("p mode held after trigger cleared");
   AST_OFF_NEVER_P: assert property ((sel_r >= SEL_OFF) [*2] |-> !p_mode)
      else $error("switching while disabled");
   AST_TRQ_LEVEL: assert property (sel_r == SEL_TORQUE
         && smsw_mag(torque_ref) >= REF_W'(trq_lvl_r) |=> p_mode)
      else $error("torque trigger missed");
   AST_TRQ_BELOW: assert property (sel_r == SEL_TORQUE
         && smsw_mag(torque_ref) < REF_W'(trq_lvl_r) |=> !p_mode)
      else $error("torque trigger false");
   AST_TRQ_RANGE: assert property (trq_lvl_r <= TRQ_LVL_MAX)
      else $error("torque level out of range");
   AST_LVL_RANGE: assert property (spd_lvl_r <= SPD_LVL_MAX
         && acc_lvl_r <= ACC_LVL_MAX && dev_lvl_r <= DEV_LVL_MAX)
      else $error("switching level out of range");
   AST_SPD_LEVEL: assert property (sel_r == SEL_SPEED
         && smsw_mag(speed_ref) < REF_W'(spd_lvl_r) |=> !p_mode)
      else $error("speed trigger false");
   AST_SPD_ABOVE: assert property (sel_r == SEL_SPEED
         && smsw_mag(speed_ref) >= REF_W'(spd_lvl_r) |=> p_mode)
      else $error("speed trigger missed");
   AST_ACC_LEVEL: assert property (sel_r == SEL_ACCEL
         && smsw_mag(accel_ref) >= REF_W'(acc_lvl_r) |=> p_mode)
      else $error("accel trigger missed");
   AST_ACC_BELOW: assert property (sel_r == SEL_ACCEL
         && smsw_mag(accel_ref) < REF_W'(acc_lvl_r) |=> !p_mode)
      else $error("accel trigger false");
   AST_DEV_LEVEL: assert property (sel_r == SEL_DEVIATION && pos_ctrl_mode
         && smsw_mag(pos_dev) >= REF_W'(dev_lvl_r) |=> p_mode)
      else $error("deviation trigger missed");
   AST_DEV_POSONLY: assert property (sel_r == SEL_DEVIATION && !pos_ctrl_mode |=> !p_mode)
      else $error("deviation switch outside position control");
   AST_SEL_NEXT: assert property (do_wr && aw_addr_r == OFS_SEL && w_strb_r[0]
         |=> sel_r == $past(w_data_r[SEL_W-1:0]))
      else $error("selection write not applied");
   AST_RESET_DEFAULT: assert property (disable iff (1'b0)
         $rose(aresetn) |-> trq_lvl_r == TRQ_LVL_RST && sel_r == SEL_RST)
      else $error("wrong reset settings");

   COV_TRQ_SWITCH: cover property (sel_r == SEL_TORQUE && $rose(p_mode));
   COV_SPD_SWITCH: cover property (sel_r == SEL_SPEED && $rose(p_mode));
   COV_DEV_SWITCH: cover property (sel_r == SEL_DEVIATION && $rose(p_mode));
   COV_BACK_TO_PI: cover property (p_mode ##1 !p_mode);
   COV_WRITE_SEL: cover property (do_wr && aw_addr_r == OFS_SEL);

endmodule

// [dv/smsw_loop_model.sv]
`timescale 1ns/100ps
module smsw_loop_model import smsw_pkg::*; (
   // clock
   input wire logic aclk,
   // references toward the mode switch
   output logic signed [REF_W-1:0] torque_ref,
   output logic signed [REF_W-1:0] speed_ref,
   output logic signed [REF_W-1:0] accel_ref,
   output logic signed [REF_W-1:0] pos_dev,
   output logic pos_ctrl_mode
);
   initial begin
      torque_ref = '0;
      speed_ref = '0;
      accel_ref = '0;
      pos_dev = '0;
      pos_ctrl_mode = 1'b0;
   end

   // loops refresh their outputs just after a control edge, never mid-cycle
   task automatic drive(input logic signed [REF_W-1:0] t, s, a, d, input logic pc);
      @(posedge aclk);
      torque_ref <= t;
      speed_ref <= s;
      accel_ref <= a;
      pos_dev <= d;
      pos_ctrl_mode <= pc;
   endtask
endmodule

// [dv/smsw_tb.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module smsw_tb import smsw_pkg::*;;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, p_mode, pc;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, rd, st;
   logic [1:0] bresp, rresp, rs;
   logic signed [REF_W-1:0] tq, sp, ac, dv;
   logic [LVL_W-1:0] lv [5];
   logic [LVL_W-1:0] mx [5];
   int bad_count = 0, cmp_count = 0;

   always #20 aclk = ~aclk;

   smsw_loop_model loop (.aclk(aclk), .torque_ref(tq), .speed_ref(sp), .accel_ref(ac),
      .pos_dev(dv), .pos_ctrl_mode(pc));
   smsw_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .torque_ref(tq), .speed_ref(sp), .accel_ref(ac),
      .pos_dev(dv), .pos_ctrl_mode(pc), .p_mode(p_mode));

   task automatic close_out();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ready is combinational, so it is looked at mid-cycle when inputs are settled
   task automatic axw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] r);
      logic ta, tv;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tv = 1'b0;
      while (!tv) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tv = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) begin
            arvalid <= 1'b0;
         end
      end
      rready <= 1'b0;
   endtask

   function automatic logic [REF_W-1:0] mag(input logic signed [REF_W-1:0] v);
      return v < 0 ? REF_W'(-v) : REF_W'(v);
   endfunction

   function automatic logic exp_p();
      case (lv[0])
         16'h0000: return mag(tq) >= REF_W'(lv[1]);
         16'h0001: return mag(sp) >= REF_W'(lv[2]);
         16'h0002: return mag(ac) >= REF_W'(lv[3]);
         16'h0003: return pc && mag(dv) >= REF_W'(lv[4]);
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic signed [REF_W-1:0] near(input logic [LVL_W-1:0] l);
      int d;
      d = int'(l) + int'($urandom % 5) - 2;
      if ($urandom % 2) begin
         d = -d;
      end
      return REF_W'(d);
   endfunction

   // level writes above the range land on the top of the range
   task automatic setr(input int i, input logic [LVL_W-1:0] v);
      axw(ADDR_W'(4 * i), DATA_W'(v), rs);
      `CHK("write resp", RESP_OKAY, rs)
      lv[i] = (i > 0 && v > mx[i]) ? mx[i] : v;
   endtask

   // mode output follows the inputs one edge later
   task automatic chk_p();
      @(posedge aclk);
      #1;
      `CHK("p_mode", exp_p(), p_mode)
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      close_out();
   end

   initial begin
      void'($urandom(7));
      mx = '{16'h000F, TRQ_LVL_MAX, SPD_LVL_MAX, ACC_LVL_MAX, DEV_LVL_MAX};
      lv = '{16'h0004, 16'h00C8, 16'h0000, 16'h0000, 16'h0000};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         axr(ADDR_W'(4 * i), rd, rs);
         `CHK("reset value", DATA_W'(lv[i]), rd)
      end
      loop.drive(32'sh7FFF_FFFF, 32'sh7FFF, 32'sh7FFF, 32'sh7FFF, 1'b1);
      chk_p();
      axr(8'h18, rd, rs);
      `CHK("unmapped read", RESP_SLVERR, rs)
      `CHK("unmapped data", 32'h0000_0000, rd)
      axw(OFS_STAT, 32'h0000_0001, rs);
      `CHK("status write", RESP_SLVERR, rs)
      for (int i = 1; i < 5; i++) begin
         setr(i, mx[i] + 16'h0001);
         axr(ADDR_W'(4 * i), rd, rs);
         `CHK("level limit", DATA_W'(mx[i]), rd)
      end
      // boundary: exactly at the level and one below, each source, both signs except accel which stays positive
      for (int s = 0; s < 4; s++) begin
         setr(0, LVL_W'(s));
         setr(s + 1, 16'h0064);
         for (int k = 0; k < 4; k++) begin
            loop.drive(k[0] ? 32'sd100 : -32'sd99, k[0] ? -32'sd100 : 32'sd99,
               k[0] ? 32'sd100 : 32'sd99, k[0] ? -32'sd100 : 32'sd99, k[1]);
            chk_p();
         end
      end
      // immediate effect of a new selection without any restart
      setr(3, 16'h0000);
      loop.drive(32'sd0, 32'sd0, 32'sd5, 32'sd0, 1'b1);
      setr(0, SEL_ACCEL);
      @(negedge aclk);
      `CHK("sel effect", 1'b1, p_mode)
      // trigger, armed and position control all stand steady here
      st = '0;
      st[STAT_PMODE_BIT] = 1'b1;
      st[STAT_ARMED_BIT] = 1'b1;
      st[STAT_POSCTL_BIT] = 1'b1;
      axr(OFS_STAT, rd, rs);
      `CHK("status", st, rd)
      `CHK("status resp", RESP_OKAY, rs)
      for (int n = 0; n < 80; n++) begin
         setr(0, LVL_W'($urandom % 8));
         if ($urandom % 3 == 0) begin
            setr(1 + ($urandom % 4), LVL_W'($urandom % 40000));
         end
         loop.drive(near(lv[1]), near(lv[2]), near(lv[3]), near(lv[4]), 1'($urandom));
         chk_p();
      end
      close_out();
   end
endmodule
